// ### fapm_ext_flash.sv
// external flash rom model hanging on the multiplexed scan pins
`timescale 1ns/1ps
module fapm_ext_flash #(
  parameter int RD_DLY = 1
) (
  input  wire logic        core_clk,
  input  wire logic [11:0] scan_out_o,
  input  wire logic [6:0]  scan_in_o,
  input  wire logic [6:0]  scan_in_oe,
  output logic      [11:0] drv_out,
  output logic      [6:0]  drv_in
);
  logic [11:0] pin_out = 12'hA5A;
  logic [6:0]  pin_in  = 7'h2B;
  logic [7:0]  bus, hi, lo, dat;
  logic        ale, rdl;
  logic        ale_q = 1'b0;
  logic [3:0]  cnt = 4'h0;
  // bus bit 7 sits on scan out 8, bus bit 0 on scan in 3
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bus[7-i] = scan_out_o[8+i];
      bus[3-i] = scan_in_o[i];
    end
    ale = scan_in_oe[4] & scan_in_o[4];
    rdl = scan_in_oe[5] & ~scan_in_o[5];
    dat = lo ^ hi ^ 8'h5C;
  end
  // undriven lines flip each cycle so a stale value can never pass for data
  always_ff @(posedge core_clk) begin
    ale_q <= ale;
    if (ale_q && !ale) begin
      lo <= bus;
      for (int i = 0; i < 8; i++) hi[i] <= scan_out_o[7-i];
    end
    cnt <= rdl ? cnt + 4'h1 : 4'h0;
    pin_out <= ~pin_out;
    pin_in <= ~pin_in;
    if (rdl && cnt >= RD_DLY) begin
      for (int i = 0; i < 4; i++) begin
        pin_out[8+i] <= dat[7-i];
        pin_in[i] <= dat[3-i];
      end
    end
  end
  assign drv_out = pin_out;
  assign drv_in  = pin_in;
endmodule

// ### fapm_pin_mux.sv
// flash access pin mux: program-port, external-code and keyboard scan pin steering
// Functional notes
// - program-enable alone connects the embedded flash to the parallel programming port
// - program-enable alone turns the scan pins into programming port pins
// - program-enable high holds the processor reset low
// - program-enable alone disables all flash write protection, boot block included
// - program-enable low with external-access off gives the embedded flash back to the processor
// - leaving program mode returns the flash command machine to array read
// - program-enable low releases the processor reset
// - program-enable low re-enables flash write protection
// - external-access routes processor code fetches to the external flash
// - external-access puts external address, data and strobes on the scan pins
// - external-access holds the embedded flash in reset
// - external flash sees read cycles only, never program or erase
// - external data writes use the data write strobe by default
// - control bit D0 set moves external data writes to the code write strobe
// - scan outputs 0..7 carry address bits 15..8 in external mode
// - scan outputs 8..11 and scan inputs 0..3 carry low address then data
// - scan input 4 is the address latch enable in external mode
// - scan input 5 is the active-low read strobe in external mode
// - scan input 6 is the active-low write strobe in external mode
// - latch enable pulses with address valid, then read strobe, data during read
`timescale 1ns/1ps
module fapm_pin_mux #(
  parameter int ALE_CYC = fapm_pkg::ALE_CYC,
  parameter int GAP_CYC = fapm_pkg::GAP_CYC,
  parameter int RD_CYC  = fapm_pkg::RD_CYC
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst,
  input  wire logic                                 program_enable_pin,
  input  wire logic                                 external_code_select_n,
  input  wire logic [fapm_pkg::REG_ADDR_W-1:0]      reg_addr,
  input  wire logic [fapm_pkg::DATA_W-1:0]          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [fapm_pkg::DATA_W-1:0]          reg_rdata,
  output logic                                      cpu_rst_n,
  input  wire logic                                 cpu_fetch_req,
  input  wire logic [fapm_pkg::ADDR_W-1:0]          cpu_fetch_addr,
  output logic                                      cpu_fetch_valid,
  output logic      [fapm_pkg::DATA_W-1:0]          cpu_fetch_data,
  input  wire logic                                 cpu_external_move_instruction_wr,
  output logic                                      data_wr_strobe_n,
  output logic                                      code_wr_strobe_n,
  output logic                                      flash_prog_sel,
  output logic      [fapm_pkg::ADDR_W-1:0]          flash_addr,
  output logic                                      flash_rd,
  input  wire logic [fapm_pkg::DATA_W-1:0]          flash_rdata,
  input  wire logic                                 flash_rd_valid,
  output logic                                      flash_wr,
  output logic      [fapm_pkg::DATA_W-1:0]          flash_wdata,
  output logic                                      flash_wp_disable,
  output logic                                      flash_read_array,
  output logic                                      flash_rst,
  input  wire logic [fapm_pkg::SCAN_OUT_W-1:0]      kbd_scan_out,
  input  wire logic [fapm_pkg::SCAN_OUT_W-1:0]      kbd_scan_oe,
  output logic      [fapm_pkg::SCAN_IN_W-1:0]       kbd_scan_in,
  input  wire logic [fapm_pkg::SCAN_OUT_W-1:0]      scan_out_i,
  output logic      [fapm_pkg::SCAN_OUT_W-1:0]      scan_out_o,
  output logic      [fapm_pkg::SCAN_OUT_W-1:0]      scan_out_oe,
  input  wire logic [fapm_pkg::SCAN_IN_W-1:0]       scan_in_i,
  output logic      [fapm_pkg::SCAN_IN_W-1:0]       scan_in_o,
  output logic      [fapm_pkg::SCAN_IN_W-1:0]       scan_in_oe
);
  // counters are CNT_W wide and the gap state spends its first cycle on address hold
  if (ALE_CYC < 1 || ALE_CYC > 15 || GAP_CYC < 2 || GAP_CYC > 15 || RD_CYC < 1 || RD_CYC > 15)
  begin : g_bad_timing
    $error("fapm_pin_mux: timing counts out of range");
  end

  localparam logic [fapm_pkg::CNT_W-1:0] ALE_LOAD = fapm_pkg::CNT_W'(ALE_CYC - 1);
  localparam logic [fapm_pkg::CNT_W-1:0] GAP_LOAD = fapm_pkg::CNT_W'(GAP_CYC - 1);
  localparam logic [fapm_pkg::CNT_W-1:0] RD_LOAD  = fapm_pkg::CNT_W'(RD_CYC - 1);

  // gathers the multiplexed bus from its split pin groups, bit 7 on scan_out 8
  function automatic logic [7:0] ad_from_pins(input logic [11:0] so, input logic [6:0] si);
    ad_from_pins = {so[8], so[9], so[10], so[11], si[0], si[1], si[2], si[3]};
  endfunction

  // mode decode: both pins asserted selects external mode, external access wins
  logic prog_mode;
  logic ext_mode;
  logic int_mode;
  assign ext_mode = !external_code_select_n;
  assign prog_mode = program_enable_pin && !ext_mode;
  assign int_mode = !program_enable_pin && !ext_mode;

  // ---------------- mode transitions ----------------
  logic prev_prog;
  logic next_prev_prog;
  logic next_cpu_rst_n;
  logic next_flash_read_array;

  // reset release and read-array request follow program-enable one edge later
  always_comb begin
    next_prev_prog = prog_mode;
    next_cpu_rst_n = !program_enable_pin;
    next_flash_read_array = prev_prog && !prog_mode;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_prog        <= 1'b0;
      cpu_rst_n        <= 1'b0;
      flash_read_array <= 1'b0;
    end else begin
      prev_prog        <= next_prev_prog;
      cpu_rst_n        <= next_cpu_rst_n;
      flash_read_array <= next_flash_read_array;
    end
  end

  // protection and reset of the embedded flash track the decoded mode
  assign flash_wp_disable = prog_mode;
  assign flash_rst = ext_mode;
  assign flash_prog_sel = prog_mode;

  // ---------------- software registers ----------------
  logic [fapm_pkg::DATA_W-1:0] special_function_ctrl;
  logic [fapm_pkg::DATA_W-1:0] next_special_function_ctrl;
  logic [fapm_pkg::DATA_W-1:0] next_reg_rdata;
  logic                        code_write_select;
  logic                        fetch_busy;

  assign code_write_select = special_function_ctrl[fapm_pkg::CODE_WRITE_SELECT_BIT];

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_special_function_ctrl = special_function_ctrl;
    next_reg_rdata = 8'h00;
    if (reg_wr && reg_addr == fapm_pkg::REG_SPECIAL_FUNCTION_CTRL) begin
      next_special_function_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        fapm_pkg::REG_SPECIAL_FUNCTION_CTRL: next_reg_rdata = special_function_ctrl;
        fapm_pkg::REG_MODE_STATUS: begin
          next_reg_rdata[fapm_pkg::STAT_PROG_BIT] = prog_mode;
          next_reg_rdata[fapm_pkg::STAT_EXT_BIT]  = ext_mode;
          next_reg_rdata[fapm_pkg::STAT_BUSY_BIT] = fetch_busy;
        end
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      special_function_ctrl <= fapm_pkg::SPECIAL_FUNCTION_CTRL_RESET;
      reg_rdata             <= 8'h00;
    end else begin
      special_function_ctrl <= next_special_function_ctrl;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // external move writes pick their strobe from the control bit
  assign data_wr_strobe_n = !(cpu_external_move_instruction_wr && !code_write_select);
  assign code_wr_strobe_n = !(cpu_external_move_instruction_wr && code_write_select);

  // ---------------- external code fetch ----------------
  fapm_pkg::fapm_fetch_e state;
  fapm_pkg::fapm_fetch_e next_state;
  logic [fapm_pkg::CNT_W-1:0]  cnt;
  logic [fapm_pkg::CNT_W-1:0]  next_cnt;
  logic [fapm_pkg::ADDR_W-1:0] fetch_addr;
  logic [fapm_pkg::ADDR_W-1:0] next_fetch_addr;
  logic [fapm_pkg::DATA_W-1:0] next_cpu_fetch_data;
  logic                        next_cpu_fetch_valid;

  assign fetch_busy = (state != fapm_pkg::FETCH_IDLE);

  // read-only sequencer: no write or command cycle ever reaches the external part
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_fetch_addr = fetch_addr;
    next_cpu_fetch_data = cpu_fetch_data;
    next_cpu_fetch_valid = 1'b0;
    if (int_mode && flash_rd_valid) begin
      next_cpu_fetch_data = flash_rdata;
      next_cpu_fetch_valid = 1'b1;
    end
    unique case (state)
      fapm_pkg::FETCH_IDLE: begin
        if (ext_mode && cpu_fetch_req && !cpu_fetch_valid) begin
          next_state = fapm_pkg::FETCH_ALE;
          next_cnt = ALE_LOAD;
          next_fetch_addr = cpu_fetch_addr;
        end
      end
      fapm_pkg::FETCH_ALE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_state = fapm_pkg::FETCH_GAP;
          next_cnt = GAP_LOAD;
        end
      end
      fapm_pkg::FETCH_GAP: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          next_state = fapm_pkg::FETCH_READ;
          next_cnt = RD_LOAD;
        end
      end
      fapm_pkg::FETCH_READ: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin  // data sampled at the last read cycle
          next_state = fapm_pkg::FETCH_IDLE;
          next_cpu_fetch_data = ad_from_pins(scan_out_i, scan_in_i);
          next_cpu_fetch_valid = 1'b1;
        end
      end
    endcase
    // leaving external mode aborts a fetch rather than strand the pins
    if (!ext_mode) begin
      next_state = fapm_pkg::FETCH_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state           <= fapm_pkg::FETCH_IDLE;
      cnt             <= 4'h0;
      fetch_addr      <= 16'h0000;
      cpu_fetch_data  <= 8'h00;
      cpu_fetch_valid <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      fetch_addr      <= next_fetch_addr;
      cpu_fetch_data  <= next_cpu_fetch_data;
      cpu_fetch_valid <= next_cpu_fetch_valid;
    end
  end

  logic ext_addr_latch_en;
  logic ext_read_strobe_n;
  logic ext_ad_drive;
  assign ext_addr_latch_en = (state == fapm_pkg::FETCH_ALE);
  assign ext_read_strobe_n = !(state == fapm_pkg::FETCH_READ);
  // low address is held one cycle past the latch edge, then the bus floats
  assign ext_ad_drive = ext_addr_latch_en || (state == fapm_pkg::FETCH_GAP && cnt == GAP_LOAD);

  // ---------------- parallel programming port ----------------
  logic [fapm_pkg::DATA_W-1:0] prog_addr_lo;
  logic [fapm_pkg::DATA_W-1:0] next_prog_addr_lo;
  logic [fapm_pkg::DATA_W-1:0] next_flash_wdata;
  logic                        prev_prog_wr_n;
  logic                        next_prev_prog_wr_n;
  logic                        next_flash_wr;
  logic [7:0]                  pin_ad;
  logic [7:0]                  pin_addr_hi;

  assign pin_ad = ad_from_pins(scan_out_i, scan_in_i);
  assign pin_addr_hi = {scan_out_i[0], scan_out_i[1], scan_out_i[2], scan_out_i[3],
                        scan_out_i[4], scan_out_i[5], scan_out_i[6], scan_out_i[7]};

  // low address follows the pins while the latch enable is high; write fires on strobe rise
  always_comb begin
    next_prog_addr_lo = prog_addr_lo;
    next_flash_wdata = flash_wdata;
    next_prev_prog_wr_n = prog_mode ? scan_in_i[fapm_pkg::WR_PIN] : 1'b1;
    next_flash_wr = 1'b0;
    if (prog_mode) begin
      if (scan_in_i[fapm_pkg::ALE_PIN]) begin
        next_prog_addr_lo = pin_ad;
      end
      if (!scan_in_i[fapm_pkg::WR_PIN]) begin
        next_flash_wdata = pin_ad;
      end
      next_flash_wr = !prev_prog_wr_n && scan_in_i[fapm_pkg::WR_PIN];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prog_addr_lo   <= 8'h00;
      flash_wdata    <= 8'h00;
      prev_prog_wr_n <= 1'b1;
      flash_wr       <= 1'b0;
    end else begin
      prog_addr_lo   <= next_prog_addr_lo;
      flash_wdata    <= next_flash_wdata;
      prev_prog_wr_n <= next_prev_prog_wr_n;
      flash_wr       <= next_flash_wr;
    end
  end

  // embedded flash address and read come from the port owning it
  always_comb begin
    flash_addr = cpu_fetch_addr;
    flash_rd = cpu_fetch_req && int_mode && !cpu_fetch_valid;
    if (prog_mode) begin
      flash_addr = {pin_addr_hi, prog_addr_lo};
      flash_rd = !scan_in_i[fapm_pkg::RD_PIN];
    end
  end

  // ---------------- scan pin steering ----------------
  logic [7:0] ad_out;
  logic       ad_oe;

  // keyboard logic sees released keys while the pins serve another function
  always_comb begin
    scan_out_o  = kbd_scan_out;
    scan_out_oe = kbd_scan_oe;
    scan_in_o   = 7'h7F;
    scan_in_oe  = 7'h00;
    kbd_scan_in = scan_in_i;
    ad_out = 8'h00;
    ad_oe = 1'b0;
    if (ext_mode) begin
      kbd_scan_in = 7'h7F;
      for (int i = 0; i < 8; i++) begin
        scan_out_o[i]  = fetch_addr[15 - i];
        scan_out_oe[i] = 1'b1;
      end
      ad_out = fetch_addr[7:0];
      ad_oe = ext_ad_drive;
      scan_in_o[fapm_pkg::ALE_PIN]  = ext_addr_latch_en;
      scan_in_o[fapm_pkg::RD_PIN]   = ext_read_strobe_n;
      scan_in_o[fapm_pkg::WR_PIN]   = 1'b1;  // write strobe parked high
      scan_in_oe[fapm_pkg::WR_PIN:fapm_pkg::ALE_PIN] = 3'h7;
    end else if (prog_mode) begin
      kbd_scan_in = 7'h7F;
      scan_out_oe[7:0] = 8'h00;
      ad_out = flash_rdata;
      ad_oe = !scan_in_i[fapm_pkg::RD_PIN];
    end
    if (!int_mode) begin
      for (int k = 0; k < 4; k++) begin
        scan_out_o[fapm_pkg::AD_HI_PIN_BASE + k]  = ad_out[7 - k];
        scan_out_oe[fapm_pkg::AD_HI_PIN_BASE + k] = ad_oe;
        scan_in_o[k]  = ad_out[3 - k];
        scan_in_oe[k] = ad_oe;
      end
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rst_hold: assert property (
    program_enable_pin |=> !cpu_rst_n) else $error("processor reset not held");
  a_rst_release: assert property (
    !program_enable_pin ##1 !program_enable_pin |-> cpu_rst_n || $past(rst))
    else $error("processor reset not released");
  a_wp_off: assert property (
    flash_wp_disable |-> program_enable_pin && external_code_select_n)
    else $error("protection off outside program mode");
  a_read_array: assert property (
    $fell(prog_mode) |=> flash_read_array ##1 !flash_read_array)
    else $error("no read array pulse on program exit");
  a_flash_held: assert property (
    !external_code_select_n |-> flash_rst && !flash_prog_sel)
    else $error("embedded flash not held in external mode");
  a_no_ext_write: assert property (
    ext_mode |-> scan_in_oe[fapm_pkg::WR_PIN] && scan_in_o[fapm_pkg::WR_PIN])
    else $error("external write strobe moved");
  a_prog_pins_in: assert property (
    prog_mode |-> scan_out_oe[7:0] == 8'h00 && scan_in_oe[6:4] == 3'h0)
    else $error("program port pins driven");
  a_hi_addr: assert property (
    fetch_busy && ext_mode |-> scan_out_o[0] == fetch_addr[15] && scan_out_o[7] == fetch_addr[8])
    else $error("high address order wrong");
  a_ale_width: assert property (
    disable iff (rst || !ext_mode) $rose(ext_addr_latch_en) |-> ext_addr_latch_en[*5]
    ##1 !ext_addr_latch_en) else $error("latch enable width wrong");
  a_rd_gap: assert property (
    disable iff (rst || !ext_mode) $fell(ext_addr_latch_en) |-> ext_read_strobe_n[*7]
    ##1 !ext_read_strobe_n[*7] ##1 cpu_fetch_valid) else $error("read strobe timing wrong");
  a_data_strobe: assert property (
    cpu_external_move_instruction_wr && !code_write_select |-> !data_wr_strobe_n && code_wr_strobe_n)
    else $error("data write strobe not used");
  a_code_strobe: assert property (
    cpu_external_move_instruction_wr && code_write_select |-> data_wr_strobe_n && !code_wr_strobe_n)
    else $error("code write strobe not used");
  a_fetch_bound: assert property (
    disable iff (rst || !ext_mode) $rose(fetch_busy) |-> ##[19:19] cpu_fetch_valid)
    else $error("external fetch did not finish");

  c_prog_exit: cover property ($fell(prog_mode));
  c_ext_fetch: cover property (ext_mode && cpu_fetch_valid);
  c_code_write: cover property (!code_wr_strobe_n);
  c_prog_write: cover property (flash_wr);
endmodule

// ### fapm_pkg.sv
// constants and types shared by the flash access pin mux
package fapm_pkg;
  // widths
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 8;
  localparam int SCAN_OUT_W = 12;
  localparam int SCAN_IN_W  = 7;
  localparam int REG_ADDR_W = 4;
  localparam int CNT_W      = 4;

  // register offsets
  localparam logic [REG_ADDR_W-1:0] REG_SPECIAL_FUNCTION_CTRL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_MODE_STATUS           = 4'h1;

  // fields and reset values
  localparam int CODE_WRITE_SELECT_BIT = 0;
  localparam int STAT_PROG_BIT         = 0;
  localparam int STAT_EXT_BIT          = 1;
  localparam int STAT_BUSY_BIT         = 2;
  localparam logic [DATA_W-1:0] SPECIAL_FUNCTION_CTRL_RESET = 8'h00;

  // pin positions inside the scan groups
  localparam int AD_HI_PIN_BASE = 8;  // scan_out 8..11 carry bus bits 7..4
  localparam int ALE_PIN        = 4;
  localparam int RD_PIN         = 5;
  localparam int WR_PIN         = 6;

  // external fetch timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int ALE_WIDTH_NS   = 125;
  localparam int ADDR_SETUP_NS  = 86;
  localparam int ALE_TO_RD_NS   = 160;
  localparam int RD_WIDTH_NS    = 160;
  localparam int ALE_WIDTH_CYC  = (ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALE_CYC        = (ALE_WIDTH_CYC > ADDR_SETUP_CYC) ? ALE_WIDTH_CYC
                                                                   : ADDR_SETUP_CYC;
  localparam int GAP_CYC        = (ALE_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC         = (RD_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_ALE,
    FETCH_GAP,
    FETCH_READ
  } fapm_fetch_e;
endpackage

// ### tb_flash_access_pin_mux.sv
// self-checking bench for the flash access pin mux
`timescale 1ns/1ps
module tb_flash_access_pin_mux;
  logic        core_clk, rst, program_enable_pin, external_code_select_n, prog_en;
  logic        reg_wr, reg_rd, cpu_fetch_req, cpu_external_move_instruction_wr, flash_rd_valid, cpu_rst_n;
  logic        cpu_fetch_valid, data_wr_strobe_n, code_wr_strobe_n, flash_prog_sel;
  logic        flash_rd, flash_wr, flash_wp_disable, flash_read_array, flash_rst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cpu_fetch_data, flash_rdata, flash_wdata, d;
  logic [15:0] cpu_fetch_addr, flash_addr;
  logic [11:0] kbd_scan_out, kbd_scan_oe, scan_out_i, scan_out_o, scan_out_oe;
  logic [11:0] prog_out, drv_out;
  logic [6:0]  kbd_scan_in, scan_in_i, scan_in_o, scan_in_oe, prog_in, drv_in;
  int          n_errors = 0, samples_checked = 0, n;
  // rows: {pe, ea_n, rst_n, prog_sel, wp_disable, flash_rst, keyboard}
  logic [6:0]  tbl [4] = '{7'h31, 7'h6C, 7'h12, 7'h42};

  fapm_pin_mux u_fapm_pin_mux (.core_clk, .rst, .program_enable_pin,
    .external_code_select_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_rst_n, .cpu_fetch_req, .cpu_fetch_addr, .cpu_fetch_valid, .cpu_fetch_data,
    .cpu_external_move_instruction_wr, .data_wr_strobe_n, .code_wr_strobe_n, .flash_prog_sel, .flash_addr,
    .flash_rd, .flash_rdata, .flash_rd_valid, .flash_wr, .flash_wdata, .flash_wp_disable,
    .flash_read_array, .flash_rst, .kbd_scan_out, .kbd_scan_oe, .kbd_scan_in,
    .scan_out_i, .scan_out_o, .scan_out_oe, .scan_in_i, .scan_in_o, .scan_in_oe);
  // slow answer: data only five cycles into the read strobe
  fapm_ext_flash #(.RD_DLY(4)) u_fapm_ext_flash (.core_clk, .scan_out_o, .scan_in_o,
    .scan_in_oe, .drv_out, .drv_in);

  // pin level: the device wins where it drives, else tester or rom model
  assign scan_out_i = (scan_out_oe & scan_out_o) | (~scan_out_oe & (prog_en ? prog_out : drv_out));
  assign scan_in_i  = (scan_in_oe & scan_in_o) | (~scan_in_oe & (prog_en ? prog_in : drv_in));

  function automatic logic [7:0] rv(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rv[i] = x[7-i];
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // tester drive on the program port; st is {write_n, read_n, latch}
  task automatic pins(input logic [7:0] hi, input logic [7:0] lo, input logic [2:0] st);
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) prog_out[i] <= hi[7-i];
    for (int i = 0; i < 4; i++) begin
      prog_out[8+i] <= lo[7-i];
      prog_in[i] <= lo[3-i];
    end
    prog_in[6:4] <= st;
  endtask
  task automatic fetch(input logic [15:0] a);
    logic wr_ok;
    wr_ok = 1'b1;
    @(posedge core_clk);
    cpu_fetch_req <= 1'b1;
    cpu_fetch_addr <= a;
    n = 0;
    while (cpu_fetch_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
      wr_ok &= scan_in_oe[6] & scan_in_o[6];
      if (n == 1) chk(scan_in_o[4] === 1'b1 && scan_out_o[7:0] === rv(a[15:8]), "ale");
      if (n == 6) chk(scan_in_o[4] === 1'b0 && scan_in_o[5] === 1'b1, "ale low");
      if (n == 15) chk(scan_in_o[5] === 1'b0 && scan_in_oe[5] === 1'b1, "read");
    end
    chk(n == 20 && cpu_fetch_data === (a[7:0] ^ a[15:8] ^ 8'h5C), "fetch");
    chk(wr_ok === 1'b1, "write strobe parked");
    @(posedge core_clk);
    cpu_fetch_req <= 1'b0;
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // a hung handshake ends the run as a failure
  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    test_done;
  end
  // main sequence
  initial begin
    {rst, external_code_select_n, prog_in} = {2'b11, 7'h7F};
    {program_enable_pin, prog_en, reg_wr, reg_rd, cpu_fetch_req, cpu_external_move_instruction_wr} = 6'h00;
    {flash_rd_valid, reg_addr, reg_wdata, cpu_fetch_addr, flash_rdata, prog_out} = '0;
    kbd_scan_out = 12'h5A3;
    kbd_scan_oe = 12'hF0F;
    repeat (12) @(posedge core_clk);
    #1 chk(cpu_rst_n === 1'b0 && reg_rdata === 8'h00 && cpu_fetch_valid === 1'b0, "reset");
    @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, d);
    chk(d === 8'h00, "ctrl reset value");
    wr(4'h0, 8'h01);
    rd(4'h0, d);
    chk(d === 8'h01, "ctrl readback");
    @(posedge core_clk);
    cpu_external_move_instruction_wr <= 1'b1;
    #1 chk(code_wr_strobe_n === 1'b0 && data_wr_strobe_n === 1'b1, "code strobe");
    wr(4'h0, 8'h00);
    #1 chk(code_wr_strobe_n === 1'b1 && data_wr_strobe_n === 1'b0, "data strobe");
    wr(4'h1, 8'hFF);
    rd(4'h1, d);
    chk(d === 8'h00, "status read-only");
    rd(4'hF, d);
    chk(d === 8'h00, "unmapped read");
    foreach (tbl[i]) begin
      @(posedge core_clk);
      program_enable_pin <= tbl[i][6];
      external_code_select_n <= tbl[i][5];
      repeat (3) @(posedge core_clk);
      #1 chk({cpu_rst_n, flash_prog_sel, flash_wp_disable, flash_rst} === tbl[i][4:1], "mode");
      if (tbl[i][0]) chk(scan_out_o === kbd_scan_out && scan_out_oe === kbd_scan_oe, "keys");
      else chk(kbd_scan_in === 7'h7F, "keys parked");
      rd(4'h1, d);
      chk(d[1] === ~tbl[i][5], "status ext");
    end
    // internal fetch with the bench in the embedded flash's place
    @(posedge core_clk);
    cpu_external_move_instruction_wr <= 1'b0;
    program_enable_pin <= 1'b0;
    external_code_select_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cpu_fetch_req <= 1'b1;
    cpu_fetch_addr <= 16'h1234;
    @(posedge core_clk);
    #1 chk(flash_rd === 1'b1 && flash_addr === 16'h1234, "int read");
    @(posedge core_clk);
    flash_rd_valid <= 1'b1;
    flash_rdata <= 8'hA7;
    @(posedge core_clk);
    flash_rd_valid <= 1'b0;
    #1 chk(cpu_fetch_valid === 1'b1 && cpu_fetch_data === 8'hA7, "int data");
    @(posedge core_clk);
    cpu_fetch_req <= 1'b0;
    external_code_select_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    fetch(16'hC35A);
    fetch(16'h3CA5);
    // program port: latch, read, write, then leave program mode
    external_code_select_n <= 1'b1;
    program_enable_pin <= 1'b1;
    prog_en <= 1'b1;
    flash_rdata <= 8'h96;
    pins(8'hC3, 8'h5A, 3'b111);
    pins(8'hC3, 8'h5A, 3'b110);
    pins(8'hC3, 8'h00, 3'b100);
    repeat (2) @(posedge core_clk);
    #1 chk(flash_addr === 16'hC35A && flash_rd === 1'b1 && scan_out_oe[7:0] === 8'h00, "prog rd");
    chk(scan_out_oe[11:8] === 4'hF && scan_out_o[11:8] === 4'h9, "prog data out");
    pins(8'hC3, 8'h3E, 3'b010);
    repeat (3) @(posedge core_clk);
    pins(8'hC3, 8'h3E, 3'b110);
    n = 0;
    repeat (4) begin
      @(posedge core_clk);
      #1 if (flash_wr === 1'b1 && flash_wdata === 8'h3E) n++;
    end
    chk(n == 1, "prog write");
    @(posedge core_clk);
    program_enable_pin <= 1'b0;
    prog_en <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge core_clk);
      #1 if (flash_read_array === 1'b1) n++;
    end
    chk(n == 1, "read array");
    chk(cpu_rst_n === 1'b1 && flash_prog_sel === 1'b0 && flash_wp_disable === 1'b0, "exit");
    test_done;
  end
endmodule
